// >>> hdl/lfac_ctrl.sv
// lfac_ctrl: decides what the drive does when its frequency falls below the lower limit
// assumes: set and running frequencies arrive synchronous to ref_clk in the drive's units
//
// Behaviour
// - the ones digit of the action setting picks run at lower limit, stop, or sleep.
// - the tens digit picks coasting or ramping the output frequency down to zero.
// - with stop selected, a set frequency below the lower limit halts the output.
// - after such a stop, running resumes once the set frequency stays above the limit for the delay.
// - with sleep selected, a running frequency below the lower limit puts the drive to sleep.
// - from sleep, running resumes only after the set frequency stays above the limit for the full delay.
`default_nettype none
`include "lfac_map.svh"
module lfac_ctrl
  import lfac_pkg::*;
#(
  parameter int          FREQ_W      = 16,
  parameter int          DLY_W       = 16,
  parameter int unsigned TICK_CYCLES = `LFAC_DELAY_UNIT_NS / `LFAC_CLK_PERIOD_NS
)(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic [FREQ_W-1:0] set_freq,
  input  wire logic [FREQ_W-1:0] run_freq,
  output logic      [FREQ_W-1:0] out_freq,
  output logic                   drive_en,
  output logic                   coasting,
  output logic                   sleeping,
  output logic                   halted
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // frequency strictly below an active lower limit
  function automatic logic below_limit(input logic [FREQ_W-1:0] f,
                                       input logic [FREQ_W-1:0] lim);
    below_limit = (lim != '0) && (f < lim);
  endfunction

  // ones digit to action; unknown codes keep running at the limit
  function automatic lfac_action_e decode_action(input logic [3:0] ones);
    case (ones)
      `LFAC_ONES_STOP:  decode_action = LFAC_ACT_STOP;
      `LFAC_ONES_SLEEP: decode_action = LFAC_ACT_SLEEP;
      default:          decode_action = LFAC_ACT_RUN_LIM;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic        [7:0]        action_ff;
  logic        [DLY_W-1:0]  delay_ff;
  logic        [FREQ_W-1:0] lowlim_ff;
  logic        [FREQ_W-1:0] step_ff;
  logic        [31:0]       rdata_ff;
  lfac_state_e              state_ff;
  lfac_state_e              nxt_state;
  logic        [FREQ_W-1:0] out_freq_ff;
  logic        [FREQ_W-1:0] nxt_out_freq;
  logic                     drive_en_ff;
  logic                     nxt_drive_en;
  logic                     coasting_ff;
  logic                     nxt_coasting;
  logic                     sleep_dest_ff;
  logic                     nxt_sleep_dest;

  lfac_timer_if #(.DLY_W(DLY_W)) tmr_if ();

  //////////////////////////////////////////////////////////////////////////////
  // register decode

  wire logic         wr_action  = reg_wr && (reg_addr == `LFAC_ADDR_ACTION);
  wire logic         wr_delay   = reg_wr && (reg_addr == `LFAC_ADDR_DELAY);
  wire logic         wr_lowlim  = reg_wr && (reg_addr == `LFAC_ADDR_LOWLIM);
  wire logic         wr_step    = reg_wr && (reg_addr == `LFAC_ADDR_STEP);
  wire logic [31:0]  status_word;
  logic      [31:0]  nxt_rdata;

  assign status_word = {24'h000000, 1'b0, halted, sleeping, coasting,
                        drive_en, state_ff};

  // read mux; unmapped offsets read zero
  always_comb
  begin
    nxt_rdata = 32'h00000000;
    case (reg_addr)
      `LFAC_ADDR_ACTION:  nxt_rdata = 32'(action_ff);
      `LFAC_ADDR_DELAY:   nxt_rdata = 32'(delay_ff);
      `LFAC_ADDR_LOWLIM:  nxt_rdata = 32'(lowlim_ff);
      `LFAC_ADDR_STEP:    nxt_rdata = 32'(step_ff);
      `LFAC_ADDR_STATUS:  nxt_rdata = status_word;
      `LFAC_ADDR_ELAPSED: nxt_rdata = 32'(tmr_if.elapsed);
      default:            nxt_rdata = 32'h00000000;
    endcase
  end

  // software writable configuration
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      action_ff <= `LFAC_RST_ACTION;
      delay_ff  <= DLY_W'(`LFAC_RST_DELAY);
      lowlim_ff <= FREQ_W'(`LFAC_RST_LOWLIM);
      step_ff   <= FREQ_W'(`LFAC_RST_STEP);
    end
    else
    begin
      if (wr_action)
        action_ff <= reg_wdata[7:0];
      if (wr_delay)
        delay_ff <= reg_wdata[DLY_W-1:0];
      if (wr_lowlim)
        lowlim_ff <= reg_wdata[FREQ_W-1:0];
      if (wr_step)
        step_ff <= reg_wdata[FREQ_W-1:0];
    end
  end

  // read data stand one cycle after the strobe only
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || !reg_rd)
      rdata_ff <= 32'h00000000;
    else
      rdata_ff <= nxt_rdata;
  end

  //////////////////////////////////////////////////////////////////////////////
  // decoded settings and frequency compares

  wire lfac_action_e act       = decode_action(action_ff[`LFAC_ONES_MSB:`LFAC_ONES_LSB]);
  wire logic         use_decel = (action_ff[`LFAC_TENS_MSB:`LFAC_TENS_LSB]
                                  == `LFAC_TENS_DECEL);
  // a zero lower limit disables every action
  wire logic         set_below = below_limit(set_freq, lowlim_ff);
  wire logic         run_below = below_limit(run_freq, lowlim_ff);
  wire logic         set_above = (lowlim_ff != '0) && (set_freq > lowlim_ff);
  wire logic         waiting   = (state_ff == LFAC_ST_HALTED)
                                 || (state_ff == LFAC_ST_SLEEP);
  wire logic [FREQ_W-1:0] ramp_next = (out_freq_ff > step_ff)
                                      ? out_freq_ff - step_ff : '0;

  // wake count runs only while the set frequency stays above
  assign tmr_if.armed = waiting && set_above;
  assign tmr_if.delay = delay_ff;

  //////////////////////////////////////////////////////////////////////////////
  // wake delay timer

  lfac_wake_timer #(
    .TICK_CYCLES (TICK_CYCLES),
    .DLY_W       (DLY_W)
  ) u_wake_timer (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .tmr     (tmr_if.timer)
  );

  //////////////////////////////////////////////////////////////////////////////
  // action state machine

  always_comb
  begin
    nxt_state      = state_ff;
    nxt_out_freq   = out_freq_ff;
    nxt_drive_en   = drive_en_ff;
    nxt_coasting   = coasting_ff;
    nxt_sleep_dest = sleep_dest_ff;
    case (state_ff)
      LFAC_ST_RUN:
      begin
        nxt_drive_en = 1'b1;
        nxt_coasting = 1'b0;
        nxt_out_freq = set_freq;
        // keep running clamped at the lower limit
        if ((act == LFAC_ACT_RUN_LIM) && set_below)
          nxt_out_freq = lowlim_ff;
        // stop on set frequency below limit
        // sleep on running frequency below limit
        if (((act == LFAC_ACT_STOP) && set_below)
            || ((act == LFAC_ACT_SLEEP) && run_below))
        begin
          nxt_sleep_dest = (act == LFAC_ACT_SLEEP);
          if (use_decel)
          begin
            nxt_state    = LFAC_ST_DECEL;
            nxt_out_freq = ramp_next;
          end
          else
          begin
            nxt_state    = (act == LFAC_ACT_SLEEP) ? LFAC_ST_SLEEP : LFAC_ST_HALTED;
            nxt_out_freq = '0;
            nxt_drive_en = 1'b0;
            nxt_coasting = 1'b1;
          end
        end
      end
      LFAC_ST_DECEL:
      begin
        nxt_out_freq = ramp_next;
        if (ramp_next == '0)
        begin
          nxt_state    = sleep_dest_ff ? LFAC_ST_SLEEP : LFAC_ST_HALTED;
          nxt_drive_en = 1'b0;
        end
      end
      LFAC_ST_HALTED,
      LFAC_ST_SLEEP:
      begin
        nxt_out_freq = '0;
        nxt_drive_en = 1'b0;
        // wake from halt or sleep after full delay
        if (tmr_if.done)
        begin
          nxt_state    = LFAC_ST_RUN;
          nxt_drive_en = 1'b1;
          nxt_coasting = 1'b0;
          nxt_out_freq = set_freq;
        end
      end
      default:
      begin
        nxt_state    = LFAC_ST_RUN;
        nxt_out_freq = '0;
        nxt_drive_en = 1'b0;
        nxt_coasting = 1'b0;
      end
    endcase
  end

  // state and output flops
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      state_ff      <= LFAC_ST_RUN;
      out_freq_ff   <= '0;
      drive_en_ff   <= 1'b0;
      coasting_ff   <= 1'b0;
      sleep_dest_ff <= 1'b0;
    end
    else
    begin
      state_ff      <= nxt_state;
      out_freq_ff   <= nxt_out_freq;
      drive_en_ff   <= nxt_drive_en;
      coasting_ff   <= nxt_coasting;
      sleep_dest_ff <= nxt_sleep_dest;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata = rdata_ff;
  assign out_freq  = out_freq_ff;
  assign drive_en  = drive_en_ff;
  assign coasting  = coasting_ff;
  assign sleeping  = (state_ff == LFAC_ST_SLEEP);
  assign halted    = (state_ff == LFAC_ST_HALTED);

endmodule
`default_nettype wire

// >>> inc/lfac_map.svh
// lfac_map.svh: register offsets, field positions, reset values and timing figures
// assumes: included by bare name from the design files lfac_ctrl and lfac_wake_timer
`ifndef LFAC_MAP_SVH
`define LFAC_MAP_SVH

// register byte offsets
`define LFAC_ADDR_ACTION   8'h00
`define LFAC_ADDR_DELAY    8'h04
`define LFAC_ADDR_LOWLIM   8'h08
`define LFAC_ADDR_STEP     8'h0C
`define LFAC_ADDR_STATUS   8'h10
`define LFAC_ADDR_ELAPSED  8'h14

// action setting fields: ones digit and tens digit as nibbles
`define LFAC_ONES_LSB      0
`define LFAC_ONES_MSB      3
`define LFAC_TENS_LSB      4
`define LFAC_TENS_MSB      7

// ones digit codes
`define LFAC_ONES_RUN_LIM  4'h0
`define LFAC_ONES_STOP     4'h1
`define LFAC_ONES_SLEEP    4'h2
// tens digit codes
`define LFAC_TENS_COAST    4'h0
`define LFAC_TENS_DECEL    4'h1

// reset values
`define LFAC_RST_ACTION    8'h00
`define LFAC_RST_DELAY     16'h0000
`define LFAC_RST_LOWLIM    16'h0000
`define LFAC_RST_STEP      16'h0001

// one wake delay unit is 0.1 s; clock period is 50 ns
`define LFAC_DELAY_UNIT_NS 100000000
`define LFAC_CLK_PERIOD_NS 50

`endif

// >>> inc/lfac_pkg.sv
// lfac_pkg: types shared by the low-frequency action controller
// assumes: lfac_map.svh on the include path
`default_nettype none
package lfac_pkg;
  // controller states
  typedef enum logic [2:0]
  {
    LFAC_ST_RUN,
    LFAC_ST_DECEL,
    LFAC_ST_HALTED,
    LFAC_ST_SLEEP
  } lfac_state_e;

  // decoded response to a below-limit frequency
  typedef enum logic [1:0]
  {
    LFAC_ACT_RUN_LIM,
    LFAC_ACT_STOP,
    LFAC_ACT_SLEEP
  } lfac_action_e;
endpackage
`default_nettype wire

// >>> inc/lfac_timer_if.sv
// lfac_timer_if: carries the wake delay request and result between controller and timer
// assumes: one clock domain, driven by the controller and the wake timer only
`default_nettype none
interface lfac_timer_if #(
  parameter int DLY_W = 16
);
  logic             armed;   // waiting state, set frequency above limit
  logic [DLY_W-1:0] delay;   // delay in 0.1 s units
  logic             done;    // delay fully elapsed
  logic [DLY_W-1:0] elapsed; // whole units counted so far

  modport ctrl
  (
    output armed,
    output delay,
    input  done,
    input  elapsed
  );
  modport timer
  (
    input  armed,
    input  delay,
    output done,
    output elapsed
  );
endinterface
`default_nettype wire

// >>> hdl/lfac_wake_timer.sv
// lfac_wake_timer: counts how long the set frequency has stayed above the lower limit
// assumes: armed drops for at least one cycle whenever the condition is broken
`default_nettype none
`include "lfac_map.svh"
module lfac_wake_timer
  import lfac_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 2000000,
  parameter int          DLY_W       = 16
)(
  input  wire logic   ref_clk,
  input  wire logic   resetn,
  lfac_timer_if.timer tmr
);
  localparam int PRE_W = $clog2(TICK_CYCLES + 1);

  logic [PRE_W-1:0] pre_ff;
  logic [DLY_W-1:0] unit_ff;
  logic             nxt_wrap;
  logic             nxt_sat;

  // prescaler wraps once per 0.1 s; unit count saturates
  assign nxt_wrap = (pre_ff == PRE_W'(TICK_CYCLES - 1));
  assign nxt_sat  = (unit_ff == {DLY_W{1'b1}});

  //////////////////////////////////////////////////////////////////////////////
  // restart on dropout
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || !tmr.armed)
    begin
      pre_ff  <= '0;
      unit_ff <= '0;
    end
    else
    begin
      pre_ff <= nxt_wrap ? '0 : pre_ff + PRE_W'(1);
      if (nxt_wrap && !nxt_sat)
        unit_ff <= unit_ff + DLY_W'(1);
    end
  end

  assign tmr.done    = tmr.armed && (unit_ff >= tmr.delay);
  assign tmr.elapsed = unit_ff;
endmodule
`default_nettype wire

// >>> sim/lfac_ctrl_props.sv
// lfac_ctrl_props: port assertions for the low-frequency action controller
// assumes: bound into lfac_ctrl; settings change only through its register port
`default_nettype none
module lfac_ctrl_props #(
  parameter int unsigned TICK_CYCLES = 4
)(
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] set_freq,
  input wire logic [15:0] out_freq,
  input wire logic        drive_en,
  input wire logic        coasting,
  input wire logic        sleeping,
  input wire logic        halted
);
  logic [7:0]  act_ff;
  logic [15:0] lim_ff;
  logic [15:0] dly_ff;
  logic [15:0] stp_ff;
  int          above_ff;
  int          need;
  wire         below = set_freq < lim_ff;
  wire         above = set_freq > lim_ff;
  assign need = int'(dly_ff) * int'(TICK_CYCLES);

  ////////////////////////////////////////////////////////////////////////
  // mirror of settings and run length of set frequency above the limit
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      act_ff   <= 8'h00;
      lim_ff   <= 16'h0000;
      dly_ff   <= 16'h0000;
      stp_ff   <= 16'h0001;
      above_ff <= 0;
    end
    else
    begin
      if (reg_wr && reg_addr == 8'h00) act_ff <= reg_wdata[7:0];
      if (reg_wr && reg_addr == 8'h04) dly_ff <= reg_wdata[15:0];
      if (reg_wr && reg_addr == 8'h08) lim_ff <= reg_wdata[15:0];
      if (reg_wr && reg_addr == 8'h0C) stp_ff <= reg_wdata[15:0];
      above_ff <= above ? above_ff + 1 : 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  a_stop_off: assert property ((halted || sleeping) |-> !drive_en)
    else $error("output on while stopped");
  a_coast_zero: assert property (coasting |-> out_freq == 16'h0 && !drive_en)
    else $error("coast with output live");
  a_one_state: assert property (!(halted && sleeping))
    else $error("halt and sleep together");
  a_stop_coast: assert property (
    drive_en && act_ff == 8'h01 && lim_ff != 16'h0 && below |=> halted && coasting)
    else $error("stop action missed");
  a_limit_off: assert property (lim_ff == 16'h0 && drive_en |=> drive_en)
    else $error("action with zero limit");
  a_decel_end: assert property (
    act_ff == 8'h11 && $fell(drive_en) |-> !coasting && $past(out_freq) <= stp_ff)
    else $error("ramp stop ended badly");
  a_wake_min: assert property (
    $fell(halted) || $fell(sleeping) |-> above_ff + 1 >= need)
    else $error("wake before delay");
  a_wake_late: assert property (halted |-> above_ff <= need + 3)
    else $error("wake too late");

  cover property ($rose(halted));
  cover property ($rose(sleeping));
  cover property ($fell(drive_en) && !coasting);
endmodule

bind lfac_ctrl lfac_ctrl_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (
  .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .set_freq(set_freq),
  .out_freq(out_freq), .drive_en(drive_en), .coasting(coasting),
  .sleeping(sleeping), .halted(halted));
`default_nettype wire

// >>> sim/lfac_ctrl_test.sv
// lfac_ctrl_test: directed scenarios for the low-frequency action controller
// assumes: wake tick shortened to 4 cycles; bench alone drives every input
`default_nettype none
module lfac_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, resetn, reg_wr, reg_rd;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] set_freq, run_freq, out_freq;
  logic        drive_en, coasting, sleeping, halted;
  int          fails, tests_run, cyc, n;
  wire  [3:0]  st = {drive_en, coasting, sleeping, halted};

  lfac_ctrl #(.TICK_CYCLES(4)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .set_freq(set_freq),
    .run_freq(run_freq), .out_freq(out_freq), .drive_en(drive_en),
    .coasting(coasting), .sleeping(sleeping), .halted(halted));

  ////////////////////////////////////////////////////////////////////////
  // 50 ns clock
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic complete_run;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  task automatic setf(input logic [15:0] s, input logic [15:0] r);
    @(posedge ref_clk);
    set_freq <= s;
    run_freq <= r;
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  // bounded wait for a flag pattern; n counts the edges it took
  task automatic wait_st(input logic [3:0] p);
    n = 0;
    while (st !== p && n < 40)
    begin
      settle(1);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h1);
    rd(8'h24, 32'h0);
    chk(st, 32'h8);
    wr(8'h08, 32'h0001_0064);
    rd(8'h08, 32'h64);
  endtask

  task automatic t_clamp;
    setf(16'd50, 16'd150);
    settle(2);
    chk(out_freq, 32'd100);
    setf(16'd150, 16'd150);
    settle(2);
    chk(out_freq, 32'd150);
  endtask

  task automatic t_coast;
    wr(8'h04, 32'h2);
    wr(8'h00, 32'h01);
    setf(16'd50, 16'd150);
    wait_st(4'h5);
    chk(n <= 3, 32'h1);
    chk(out_freq, 32'h0);
    setf(16'd150, 16'd150);
    settle(4);
    setf(16'd50, 16'd150);
    setf(16'd150, 16'd150);
    wait_st(4'h8);
    chk(n >= 7 && n <= 11, 32'h1);
    chk(out_freq, 32'd150);
  endtask

  task automatic t_decel;
    wr(8'h0C, 32'h10);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h11);
    setf(16'd50, 16'd150);
    n = 0;
    while (drive_en === 1'b1 && n < 40)
    begin
      settle(1);
      n++;
      chk(coasting, 32'h0);
      if (drive_en === 1'b1)
        chk(out_freq, 32'(150 - 16 * n));
    end
    chk(n >= 3, 32'h1);
    chk(st, 32'h1);
    rd(8'h10, 32'h42);
    setf(16'd150, 16'd150);
    wait_st(4'h8);
    chk(n <= 3, 32'h1);
  endtask

  task automatic t_sleep;
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h02);
    setf(16'd50, 16'd50);
    wait_st(4'h6);
    chk(n <= 3, 32'h1);
    rd(8'h10, 32'h33);
    setf(16'd150, 16'd150);
    wait_st(4'h8);
    chk(n >= 3 && n <= 7, 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // reset, scenarios, verdict
  initial
  begin
    resetn    = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    set_freq  = 16'h0;
    run_freq  = 16'h0;
    fails     = 0;
    tests_run = 0;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    t_regs;
    t_clamp;
    t_coast;
    t_decel;
    t_sleep;
    complete_run;
  end

  // hang guard
  initial
  begin
    cyc = 0;
    forever
    begin
      @(posedge ref_clk);
      cyc++;
      if (cyc == 5000)
      begin
        fails++;
        complete_run;
      end
    end
  end
endmodule
`default_nettype wire
